// ---- hdl/dma_ctl_pkg.sv ----
`default_nettype none
package dma_ctl_pkg;
  // register byte offsets
  localparam logic [7:0] CTL_OFF = 8'h00;
  localparam logic [7:0] STS_OFF = 8'h04;
  localparam logic [7:0] ERR_OFF = 8'h08;
  localparam logic [7:0] DPL_OFF = 8'h0C;
  localparam logic [7:0] DPH_OFF = 8'h10;
  localparam logic [7:0] CFG_OFF = 8'h14;
  localparam logic [7:0] DEVCTL_OFF = 8'h18;
  // control bit positions
  localparam int CTL_RUN = 0;
  localparam int CTL_ABORT = 1;
  localparam int CTL_SUSPEND = 2;
  // status bit positions
  localparam int STS_ABORT = 0;
  localparam int STS_ERROR = 1;
  localparam int STS_SUSPEND = 2;
  localparam int STS_HALT = 3;
  // config bit positions
  localparam int CFG_RO = 0;
  localparam int CFG_NS = 1;
  localparam int CFG_PREFETCH = 2;
  // device control bit positions
  localparam int DEV_RO_PERMIT = 0;
  localparam int DEV_NS_PERMIT = 1;
  // reset value and response codes
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // outstanding read counter width
  localparam int OUT_W = 2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_SKIP, ST_XFER, ST_WRBACK, ST_DRAIN
  } chan_state_e;
endpackage : dma_ctl_pkg
`default_nettype wire

// ---- hdl/dma_channel_ctrl.sv ----
// Functional notes
// - software abort stops all descriptor and data read requests
// - software abort drains outstanding reads normally; writes and writeback allowed (code drops wrback_req once in ST_DRAIN)
// - descriptor pointer keeps the interrupted descriptor after any abort
// - aborts and suspend discard all prefetched descriptors
// - abort-done set after drain, or at once if idle
// - error abort stops descriptor reads, source reads and memory writes
// - error abort drains reads and drops their completions
// - error abort sets error register bits, then abort-done and error status flags
// - suspend finishes writeback, keeps pointer, sets suspend flag; at once if halted
// - run stays set while suspended
// - resume refetches current descriptor, skips it, follows next link
// - control write with run and abort zero has no effect
// - abort bit aborts; suspend with run and without abort suspends
// - run write ignored on error; else starts or resumes
// - writeback never alters next link low or final entry flag
// - run after append continues normally, refetching prefetched descriptors
// - halted channel refetches last descriptor, skips it, starts at successor
// - relaxed order only when function permit bit set
// - no snoop only when function permit bit set
// - software run set beats hardware clear in same cycle
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
module dma_channel_ctrl #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic desc_rd_req_grant,
  input wire logic data_rd_req_grant,
  input wire logic desc_rd_done,
  input wire logic desc_status_nonzero,
  input wire logic desc_is_last,
  input wire logic [63:0] desc_next_link,
  input wire logic data_rd_done,
  input wire logic data_cpl_valid,
  input wire logic xfer_done,
  input wire logic wrback_done,
  input wire logic err_detect,
  input wire logic [31:0] err_code,
  output logic desc_rd_req,
  output logic data_rd_req,
  output logic mem_wr_en,
  output logic cpl_to_write,
  output logic wrback_req,
  output logic prefetch_flush,
  output logic [63:0] fetch_addr,
  output logic req_attr_ro,
  output logic req_attr_ns,
  output logic chan_busy
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic run_reg;
  logic [31:0] sts_reg;
  logic [31:0] err_reg;
  logic [31:0] dpl_reg;
  logic [31:0] dph_reg;
  logic [31:0] cfg_reg;
  logic [31:0] devctl_reg;
  logic susp_req_reg;
  logic err_abort_reg;
  logic [dma_ctl_pkg::OUT_W-1:0] outst_reg;
  dma_ctl_pkg::chan_state_e state_reg;

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wr_fire;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  // address and data capture in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= dma_ctl_pkg::WORD_RESET;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= byte_merge(dma_ctl_pkg::WORD_RESET, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dma_ctl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (awaddr_reg)
        dma_ctl_pkg::CTL_OFF, dma_ctl_pkg::STS_OFF, dma_ctl_pkg::ERR_OFF,
        dma_ctl_pkg::DPL_OFF, dma_ctl_pkg::DPH_OFF, dma_ctl_pkg::CFG_OFF,
        dma_ctl_pkg::DEVCTL_OFF: s_axi_bresp <= dma_ctl_pkg::RESP_OKAY;
        default: s_axi_bresp <= dma_ctl_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control write decode
  // ------------------------------------------------------------
  logic ctl_wr;
  logic cmd_abort;
  logic cmd_suspend;
  logic cmd_run;
  logic err_flag;

  assign ctl_wr = wr_fire && (awaddr_reg == dma_ctl_pkg::CTL_OFF);
  assign err_flag = sts_reg[dma_ctl_pkg::STS_ERROR];
  assign cmd_abort = ctl_wr && wdata_reg[dma_ctl_pkg::CTL_ABORT];
  assign cmd_suspend = ctl_wr && wdata_reg[dma_ctl_pkg::CTL_RUN]
                       && !wdata_reg[dma_ctl_pkg::CTL_ABORT]
                       && wdata_reg[dma_ctl_pkg::CTL_SUSPEND];
  assign cmd_run = ctl_wr && wdata_reg[dma_ctl_pkg::CTL_RUN]
                   && !wdata_reg[dma_ctl_pkg::CTL_ABORT]
                   && !wdata_reg[dma_ctl_pkg::CTL_SUSPEND] && !err_flag;

  logic idle;
  logic drain_done;
  logic draining;
  assign idle = (state_reg == dma_ctl_pkg::ST_IDLE);
  assign draining = (state_reg == dma_ctl_pkg::ST_DRAIN);
  assign drain_done = draining && (outst_reg == '0);

  // ------------------------------------------------------------
  // channel state machine
  // ------------------------------------------------------------
  logic hw_clear_run;
  assign hw_clear_run = (state_reg == dma_ctl_pkg::ST_WRBACK) && wrback_done
                        && !susp_req_reg && desc_is_last
                        || drain_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dma_ctl_pkg::ST_IDLE;
      err_abort_reg <= 1'b0;
      susp_req_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        dma_ctl_pkg::ST_IDLE: begin
          // resume and restart refetch current descriptor
          if (cmd_run) begin
            state_reg <= dma_ctl_pkg::ST_FETCH;
            susp_req_reg <= 1'b0;
          end
        end
        dma_ctl_pkg::ST_FETCH, dma_ctl_pkg::ST_SKIP, dma_ctl_pkg::ST_XFER: begin
          if (err_detect) begin
            state_reg <= dma_ctl_pkg::ST_DRAIN;
            err_abort_reg <= 1'b1;
          end else if (cmd_abort) begin
            state_reg <= dma_ctl_pkg::ST_DRAIN;
          end else if (state_reg == dma_ctl_pkg::ST_FETCH && desc_rd_done) begin
            state_reg <= desc_status_nonzero ? dma_ctl_pkg::ST_SKIP
                                             : dma_ctl_pkg::ST_XFER;
          end else if (state_reg == dma_ctl_pkg::ST_SKIP) begin
            state_reg <= (susp_req_reg || cmd_suspend) ? dma_ctl_pkg::ST_IDLE
                                                       : dma_ctl_pkg::ST_FETCH;
          end else if (state_reg == dma_ctl_pkg::ST_XFER && xfer_done) begin
            state_reg <= dma_ctl_pkg::ST_WRBACK;
          end
          if (cmd_suspend) begin
            susp_req_reg <= 1'b1;
          end
        end
        dma_ctl_pkg::ST_WRBACK: begin
          if (err_detect) begin
            state_reg <= dma_ctl_pkg::ST_DRAIN;
            err_abort_reg <= 1'b1;
          end else if (cmd_abort) begin
            state_reg <= dma_ctl_pkg::ST_DRAIN;
          end else if (wrback_done) begin
            if (susp_req_reg || cmd_suspend || desc_is_last) begin
              state_reg <= dma_ctl_pkg::ST_IDLE;
            end else begin
              state_reg <= dma_ctl_pkg::ST_FETCH;
            end
          end else if (cmd_suspend) begin
            susp_req_reg <= 1'b1;
          end
        end
        dma_ctl_pkg::ST_DRAIN: begin
          if (drain_done) begin
            state_reg <= dma_ctl_pkg::ST_IDLE;
            err_abort_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // outstanding read counter
  // ------------------------------------------------------------
  logic rd_issue;
  logic rd_retire;
  assign rd_issue = (desc_rd_req && desc_rd_req_grant) || (data_rd_req && data_rd_req_grant);
  assign rd_retire = desc_rd_done || data_rd_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outst_reg <= '0;
    end else if (rd_issue && !rd_retire) begin
      outst_reg <= outst_reg + 1'b1;
    end else if (rd_retire && !rd_issue && outst_reg != '0) begin
      outst_reg <= outst_reg - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // run bit, status and pointers
  // ------------------------------------------------------------
  // software set beats hardware clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= 1'b0;
    end else if (cmd_run) begin
      run_reg <= 1'b1;
    end else if (hw_clear_run && !susp_req_reg) begin
      run_reg <= 1'b0;
    end
  end

  // status flags, set wins over clear
  always_ff @(posedge aclk) begin
    logic [31:0] s;
    s = sts_reg;
    if (!aresetn) begin
      sts_reg <= dma_ctl_pkg::WORD_RESET;
    end else begin
      if (wr_fire && awaddr_reg == dma_ctl_pkg::STS_OFF) begin
        s = s & ~byte_merge(dma_ctl_pkg::WORD_RESET, wdata_reg, 4'hF); // write one to clear
      end
      // abort done after drain or at once
      if (drain_done || (cmd_abort && idle)) begin
        s[dma_ctl_pkg::STS_ABORT] = 1'b1;
      end
      if (drain_done && err_abort_reg) begin
        s[dma_ctl_pkg::STS_ERROR] = 1'b1;
      end
      if ((cmd_suspend && idle)
          || (state_reg == dma_ctl_pkg::ST_WRBACK && wrback_done && (susp_req_reg || cmd_suspend))
          || (state_reg == dma_ctl_pkg::ST_SKIP && (susp_req_reg || cmd_suspend))) begin
        s[dma_ctl_pkg::STS_SUSPEND] = 1'b1;
      end
      if (state_reg == dma_ctl_pkg::ST_WRBACK && wrback_done && desc_is_last
          && !susp_req_reg) begin
        s[dma_ctl_pkg::STS_HALT] = 1'b1;
      end
      sts_reg <= s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_reg <= dma_ctl_pkg::WORD_RESET;
    end else begin
      err_reg <= (wr_fire && awaddr_reg == dma_ctl_pkg::ERR_OFF) ? (err_reg & ~wdata_reg)
                                                                  : err_reg;
      if (err_detect && !draining) begin
        err_reg <= err_reg | err_code;
      end
    end
  end

  // next link held from the fetch for the skip step
  logic [63:0] link_reg;
  logic [63:0] link_now;
  assign link_now = (state_reg == dma_ctl_pkg::ST_SKIP) ? link_reg : desc_next_link;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_reg <= '0;
    end else if (desc_rd_done) begin
      link_reg <= desc_next_link;
    end
  end

  // pointers and configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dpl_reg <= dma_ctl_pkg::WORD_RESET;
      dph_reg <= dma_ctl_pkg::WORD_RESET;
      cfg_reg <= dma_ctl_pkg::WORD_RESET;
      devctl_reg <= dma_ctl_pkg::WORD_RESET;
    end else begin
      if (wr_fire && awaddr_reg == dma_ctl_pkg::DPL_OFF && idle) dpl_reg <= wdata_reg;
      if (wr_fire && awaddr_reg == dma_ctl_pkg::DPH_OFF && idle) dph_reg <= wdata_reg;
      if (wr_fire && awaddr_reg == dma_ctl_pkg::CFG_OFF) cfg_reg <= wdata_reg;
      if (wr_fire && awaddr_reg == dma_ctl_pkg::DEVCTL_OFF) devctl_reg <= wdata_reg;
      // pointer only advances on normal progress
      if ((state_reg == dma_ctl_pkg::ST_SKIP && !susp_req_reg && !cmd_suspend
           && !cmd_abort && !err_detect)
          || (state_reg == dma_ctl_pkg::ST_WRBACK && wrback_done && !susp_req_reg
              && !cmd_suspend && !cmd_abort && !err_detect && !desc_is_last)) begin
        dpl_reg <= link_now[31:0];
        dph_reg <= link_now[63:32];
      end
    end
  end

  // ------------------------------------------------------------
  // request outputs
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc_rd_req <= 1'b0;
      data_rd_req <= 1'b0;
      mem_wr_en <= 1'b0;
      cpl_to_write <= 1'b0;
      wrback_req <= 1'b0;
      prefetch_flush <= 1'b0;
      fetch_addr <= '0;
      req_attr_ro <= 1'b0;
      req_attr_ns <= 1'b0;
      chan_busy <= 1'b0;
    end else begin
      desc_rd_req <= (state_reg == dma_ctl_pkg::ST_FETCH) && !cmd_abort && !err_detect
                     && !desc_rd_done && outst_reg == '0;
      data_rd_req <= (state_reg == dma_ctl_pkg::ST_XFER) && !cmd_abort && !err_detect;
      mem_wr_en <= !err_abort_reg && !err_detect;
      // drain converts completions; error drain drops them
      cpl_to_write <= data_cpl_valid && !err_abort_reg && !err_detect;
      // writeback touches only the status byte
      wrback_req <= (state_reg == dma_ctl_pkg::ST_WRBACK) && !wrback_done && !err_detect;
      // flush on abort or suspend; and on run append
      prefetch_flush <= cmd_abort || cmd_suspend || err_detect || (cmd_run && !idle);
      fetch_addr <= {dph_reg, dpl_reg};
      req_attr_ro <= devctl_reg[dma_ctl_pkg::DEV_RO_PERMIT] && cfg_reg[dma_ctl_pkg::CFG_RO];
      req_attr_ns <= devctl_reg[dma_ctl_pkg::DEV_NS_PERMIT] && cfg_reg[dma_ctl_pkg::CFG_NS];
      chan_busy <= !idle;
    end
  end

  // ------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= dma_ctl_pkg::WORD_RESET;
      s_axi_rresp <= dma_ctl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dma_ctl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dma_ctl_pkg::CTL_OFF: s_axi_rdata <= {29'h0, susp_req_reg, 1'b0, run_reg};
        dma_ctl_pkg::STS_OFF: s_axi_rdata <= sts_reg;
        dma_ctl_pkg::ERR_OFF: s_axi_rdata <= err_reg;
        dma_ctl_pkg::DPL_OFF: s_axi_rdata <= dpl_reg;
        dma_ctl_pkg::DPH_OFF: s_axi_rdata <= dph_reg;
        dma_ctl_pkg::CFG_OFF: s_axi_rdata <= cfg_reg;
        dma_ctl_pkg::DEVCTL_OFF: s_axi_rdata <= devctl_reg;
        default: begin
          s_axi_rdata <= dma_ctl_pkg::WORD_RESET;
          s_axi_rresp <= dma_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  no_read_abort_a: assert property (draining |=> !desc_rd_req && !data_rd_req)
    else $error("read request during abort drain");
  abort_idle_flag_a: assert property (cmd_abort && idle |=>
    sts_reg[dma_ctl_pkg::STS_ABORT])
    else $error("idle abort did not set abort flag");
  drain_flag_a: assert property (drain_done |=> sts_reg[dma_ctl_pkg::STS_ABORT])
    else $error("drain end without abort flag");
  err_flags_a: assert property (drain_done && err_abort_reg |=>
    sts_reg[dma_ctl_pkg::STS_ERROR])
    else $error("error abort without error flag");
  err_drop_a: assert property (err_abort_reg |=> !cpl_to_write)
    else $error("completion converted during error abort");
  err_nowr_a: assert property (err_detect |=> !mem_wr_en)
    else $error("memory write enabled after error");
  ptr_hold_a: assert property (draining |=> $stable({dph_reg, dpl_reg}) || idle)
    else $error("pointer moved during abort");
  flush_a: assert property (cmd_abort || cmd_suspend |=> prefetch_flush)
    else $error("prefetch not flushed");
  ro_gate_a: assert property (!devctl_reg[dma_ctl_pkg::DEV_RO_PERMIT] |=>
    !req_attr_ro)
    else $error("relaxed order without permit");
  ns_gate_a: assert property (!devctl_reg[dma_ctl_pkg::DEV_NS_PERMIT] |=>
    !req_attr_ns)
    else $error("no snoop without permit");
  run_win_a: assert property (cmd_run |=> run_reg)
    else $error("software run lost");
  susp_idle_a: assert property (cmd_suspend && idle |=>
    sts_reg[dma_ctl_pkg::STS_SUSPEND])
    else $error("halted suspend flag late");

  cov_abort_c: cover property (cmd_abort && !idle ##[1:50] drain_done);
  cov_err_c: cover property (err_detect ##[1:50] drain_done);
  cov_susp_c: cover property (cmd_suspend && !idle ##[1:50] sts_reg[dma_ctl_pkg::STS_SUSPEND]);
endmodule : dma_channel_ctrl
`default_nettype wire

// ---- sim/fabric_model.sv ----
`default_nettype none
module fabric_model #(
  parameter logic [63:0] NEXT = 64'h0000_0000_0000_2000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] dly,
  input wire logic last_in,
  input wire logic skip_in,
  input wire logic desc_rd_req,
  input wire logic data_rd_req,
  input wire logic wrback_req,
  output logic desc_rd_req_grant,
  output logic data_rd_req_grant,
  output logic desc_rd_done,
  output logic data_rd_done,
  output logic data_cpl_valid,
  output logic xfer_done,
  output logic wrback_done,
  output logic desc_status_nonzero,
  output logic desc_is_last,
  output logic [63:0] desc_next_link
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dc, rc, wc;
  logic fv;
  // ----------------------------------------
  // request service
  // ----------------------------------------
  // every granted read answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {desc_rd_req_grant, data_rd_req_grant, dc, rc, wc} <= 14'h0000;
    end else begin
      desc_rd_req_grant <= desc_rd_req && dc == 4'h0 && !desc_rd_req_grant;
      data_rd_req_grant <= data_rd_req && rc == 4'h0 && !data_rd_req_grant;
      dc <= desc_rd_req_grant ? dly : dc - {3'h0, |dc};
      rc <= data_rd_req_grant ? dly : rc - {3'h0, |rc};
      wc <= (wrback_req && wc == 4'h0) ? dly : wc - {3'h0, |wc};
    end
  end
  // answers; fields only valid with a done, inverted otherwise
  assign desc_rd_done = dc == 4'h3;
  assign data_rd_done = rc == 4'h3;
  assign data_cpl_valid = rc == 4'h3;
  assign xfer_done = rc == 4'h2;
  assign wrback_done = wc == 4'h3;
  assign fv = desc_rd_done | wrback_done;
  assign desc_is_last = fv ? last_in : !last_in;
  assign desc_status_nonzero = fv ? skip_in : !skip_in;
  assign desc_next_link = fv ? NEXT : ~NEXT;
endmodule : fabric_model
`default_nettype wire

// ---- sim/test_dma_channel_abort_suspend_control.sv ----
`default_nettype none
module test_dma_channel_abort_suspend_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, last_in, skip_in, err_detect;
  logic [3:0] dly, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, err_code, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic desc_rd_req_grant, data_rd_req_grant, desc_rd_done, desc_status_nonzero, desc_is_last;
  logic data_rd_done, data_cpl_valid, xfer_done, wrback_done, desc_rd_req, data_rd_req;
  logic mem_wr_en, cpl_to_write, wrback_req, prefetch_flush, req_attr_ro, req_attr_ns, chan_busy;
  logic [63:0] desc_next_link, fetch_addr;
  int n_errors, num_checks, ncpl, nflush, nbad;
  dma_channel_ctrl u_dma_channel_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .desc_rd_req_grant, .data_rd_req_grant,
    .desc_rd_done, .desc_status_nonzero, .desc_is_last, .desc_next_link, .data_rd_done,
    .data_cpl_valid, .xfer_done, .wrback_done, .err_detect, .err_code, .desc_rd_req,
    .data_rd_req, .mem_wr_en, .cpl_to_write, .wrback_req, .prefetch_flush, .fetch_addr,
    .req_attr_ro, .req_attr_ns, .chan_busy);
  fabric_model u_fabric_model (.aclk, .aresetn, .dly, .last_in, .skip_in, .desc_rd_req,
    .data_rd_req, .wrback_req, .desc_rd_req_grant, .data_rd_req_grant, .desc_rd_done,
    .data_rd_done, .data_cpl_valid, .xfer_done, .wrback_done, .desc_status_nonzero,
    .desc_is_last, .desc_next_link);
  // ----------------------------------------
  // clock, monitors and bus tasks
  // ----------------------------------------
  always #4 aclk = ~aclk;
  // count completions written, flushes, transfers of skipped descriptors
  always @(posedge aclk) begin
    if (cpl_to_write) ncpl++;
    if (prefetch_flush) nflush++;
    if (data_rd_req_grant && skip_in) nbad++;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end while (pa || pw || !s_axi_bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    v = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  // poll the flag before going on
  task automatic wait_sts(input int b);
    rd(dma_ctl_pkg::STS_OFF);
    while (!v[b]) rd(dma_ctl_pkg::STS_OFF);
  endtask : wait_sts
  // refetched descriptor done, follow its link to a final one
  task automatic skip_to_next();
    skip_in <= 1'b1;
    last_in <= 1'b0;
    wr(dma_ctl_pkg::CTL_OFF, 32'h1);
    while (fetch_addr !== 64'h2000) @(posedge aclk);
    skip_in <= 1'b0;
    last_in <= 1'b1;
    wait_sts(dma_ctl_pkg::STS_HALT);
    check(fetch_addr, 64'h2000);
    check(nbad, 0);
    wr(dma_ctl_pkg::STS_OFF, 32'hF);
  endtask : skip_to_next
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i));
      check(v, 32'h0);
      check(resp, i == 7 ? dma_ctl_pkg::RESP_SLVERR : dma_ctl_pkg::RESP_OKAY);
    end
    for (int i = 0; i < 16; i++) begin
      wr(dma_ctl_pkg::CFG_OFF, {30'h0, i[1:0]});
      wr(dma_ctl_pkg::DEVCTL_OFF, {30'h0, i[3:2]});
      repeat (2) @(posedge aclk);
      check({req_attr_ns, req_attr_ro}, i[1:0] & i[3:2]);
    end
  endtask : t_regs
  task automatic t_idle();
    wr(dma_ctl_pkg::CTL_OFF, 32'h4);
    repeat (3) @(posedge aclk);
    check({chan_busy, desc_rd_req}, 2'b00);
    rd(dma_ctl_pkg::STS_OFF);
    check(v, 32'h0);
    wr(dma_ctl_pkg::CTL_OFF, 32'h5);
    rd(dma_ctl_pkg::STS_OFF);
    check(v[dma_ctl_pkg::STS_SUSPEND], 1'b1);
    wr(dma_ctl_pkg::CTL_OFF, 32'h2);
    rd(dma_ctl_pkg::STS_OFF);
    check(v[dma_ctl_pkg::STS_ABORT], 1'b1);
    wr(dma_ctl_pkg::STS_OFF, 32'hF);
  endtask : t_idle
  // skip policy, no chaining, lists below 4 GB
  task automatic t_append();
    wr(dma_ctl_pkg::DPL_OFF, 32'h1000);
    last_in <= 1'b1;
    wr(dma_ctl_pkg::CTL_OFF, 32'h1);
    wait_sts(dma_ctl_pkg::STS_HALT);
    check(fetch_addr, 64'h1000);
    wr(dma_ctl_pkg::STS_OFF, 32'hF);
    skip_to_next();
  endtask : t_append
  task automatic t_abort(input logic err);
    int c0, f0;
    dly <= 4'hC;
    last_in <= 1'b0;
    wr(dma_ctl_pkg::DPL_OFF, {19'h0, err, 12'h000});
    wr(dma_ctl_pkg::CTL_OFF, 32'h1);
    while (!data_rd_req_grant) @(posedge aclk);
    c0 = ncpl;
    f0 = nflush;
    err_code <= 32'h10;
    err_detect <= err;
    if (!err) wr(dma_ctl_pkg::CTL_OFF, 32'h2);
    @(posedge aclk);
    err_detect <= 1'b0;
    repeat (2) @(posedge aclk);
    check({desc_rd_req, data_rd_req}, 2'b00);
    check(mem_wr_en & err, 1'b0);
    wait_sts(dma_ctl_pkg::STS_ABORT);
    check(v[1:0], {err, 1'b1});
    check(ncpl > c0, !err);
    check(nflush > f0, 1'b1);
    check(fetch_addr, {51'h0, err, 12'h000});
    rd(dma_ctl_pkg::ERR_OFF);
    check(v, err ? 32'h10 : 32'h0);
    last_in <= 1'b1;
    wr(dma_ctl_pkg::CTL_OFF, 32'h1);
    repeat (4) @(posedge aclk);
    check(chan_busy, !err);
    wr(dma_ctl_pkg::ERR_OFF, 32'h10);
    if (!err) wait_sts(dma_ctl_pkg::STS_HALT);
    wr(dma_ctl_pkg::STS_OFF, 32'hF);
  endtask : t_abort
  task automatic t_susp();
    wr(dma_ctl_pkg::DPL_OFF, 32'h5000);
    last_in <= 1'b0;
    wr(dma_ctl_pkg::CTL_OFF, 32'h1);
    while (!wrback_req) @(posedge aclk);
    wr(dma_ctl_pkg::CTL_OFF, 32'h5);
    wait_sts(dma_ctl_pkg::STS_SUSPEND);
    check(fetch_addr, 64'h5000);
    rd(dma_ctl_pkg::CTL_OFF);
    check(v[dma_ctl_pkg::CTL_RUN], 1'b1);
    wr(dma_ctl_pkg::STS_OFF, 32'hF);
    skip_to_next();
  endtask : t_susp
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {last_in, skip_in, err_detect, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'h00;
    {s_axi_bready, s_axi_rready, s_axi_wstrb, dly} = 10'h3F4;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_code} = 80'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_idle();
    t_append();
    t_abort(1'b0);
    t_abort(1'b1);
    t_susp();
    end_sim();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    end_sim();
  end
endmodule : test_dma_channel_abort_suspend_control
`default_nettype wire
